// ===== opp_pkg.sv
// Shared constants for the one-time-programmable memory programmer
package opp_pkg;
    // Device geometry and timer width
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int TMR_W = 14;

    // Clock period and printed times, in ns
    localparam int CLK_NS = 8;
    localparam int T_PULSE_NS = 100000; // program_pulse_width, nominal
    localparam int T_PULSE_MIN_NS = 95000;
    localparam int T_PULSE_MAX_NS = 105000;
    localparam int T_SETUP_NS = 2000; // address, data, enable and supply setup
    localparam int T_VALID_NS = 150; // output_valid_delay
    localparam int T_RELEASE_NS = 130; // output_release_delay

    // Cycle counts: waits on device delays round up
    localparam int CYC_PULSE = T_PULSE_NS / CLK_NS;
    localparam int CYC_SETUP = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_VALID = (T_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_RELEASE = (T_RELEASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LAT = 2;
    localparam int CYC_SAMPLE = CYC_VALID + SYNC_LAT;
    localparam int MAX_RETRY = 10;

    // Sequencer phases
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_RETRY = 2'h1;
    localparam logic [1:0] PH_FINAL = 2'h2;
    localparam logic [1:0] PH_IDENT = 2'h3;

    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_VCC = 12'h002,
        ST_VPP = 12'h004,
        ST_SETUP = 12'h008,
        ST_PULSE = 12'h010,
        ST_HOLD = 12'h020,
        ST_OE = 12'h040,
        ST_REL = 12'h080,
        ST_DN_VPP = 12'h100,
        ST_DN_VCC = 12'h200,
        ST_DONE = 12'h400,
        ST_SPARE = 12'h800
    } opp_state_e;
endpackage

// ===== opp_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Down counter that times each sequencer state
module opp_timer
    import opp_pkg::*;
(
    // Clock and control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Load and status
    input wire logic load,
    input wire logic [TMR_W-1:0] load_val,
    output logic expired
);
    logic [TMR_W-1:0] cnt;

    // Reload wins over counting so a new state never sees a stale zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cnt <= '0;
        else if (clk_en && load)
            cnt <= load_val;
        else if (clk_en && cnt != '0)
            cnt <= cnt - 1'b1;
    end

    assign expired = (cnt == '0);
endmodule // opp_timer
`default_nettype wire

// ===== opp_programmer.sv
//
// Contract
// - Each program strobe pulse is held low between 95 and 105 us, nominally 100 us.
// - Programming starts at address zero, then main supply rises to 6.5 V, then 13.0 V.
// - The first pass gives every address exactly one pulse with no verification.
// - The second pass gives a failing byte up to ten more pulses, verifying after each.
// - A byte still failing after ten retry pulses makes the whole device fail.
// - A verified byte advances the address until every address has been checked.
// - Both supplies then drop to 5.0 V and every byte is read back and compared; the code ends the read at the first miscompare.
// - Data is sampled only 150 ns after output enable, and 130 ns is allowed for release.
// - Main supply is applied no later and removed no earlier than the programming supply.
// - In identification mode the low address bit picks maker code or device code.
// - Identification mode is entered by raising the high-voltage address line.
// - During identification every other address line is held low.
//
`timescale 1ns/1ns
`default_nettype none
module opp_programmer
    import opp_pkg::*;
#(
    parameter int PULSE_CYC = CYC_PULSE
)
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // User commands
    input wire logic start_prog,
    input wire logic start_id,
    input wire logic id_sel,
    input wire logic [ADDR_W-1:0] last_addr,
    // Source data, same clock, one cycle after src_addr
    output logic [ADDR_W-1:0] src_addr,
    input wire logic [DATA_W-1:0] src_data,
    // Status
    output logic busy,
    output logic done,
    output logic passed,
    output logic failed,
    output logic [DATA_W-1:0] id_byte,
    // Device pins
    output logic [ADDR_W-1:0] addr,
    output logic dq_oe,
    output logic [DATA_W-1:0] dq_out,
    input wire logic [DATA_W-1:0] dq_in,
    output logic ce_n,
    output logic oe_n,
    output logic program_strobe_n,
    output logic id_high_voltage_line,
    output logic vcc_prog_en,
    output logic vpp_prog_en
);
    opp_state_e state, next_state;
    logic [1:0] ph, next_ph;
    logic [3:0] retry, next_retry;
    logic [ADDR_W-1:0] next_addr;
    logic next_fail, fail_flag;
    logic [DATA_W-1:0] dq_meta, dq_sync;
    logic tmr_done, tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic read_ok;

    // Handy decodes
    wire adv = clk_en && tmr_done;
    wire is_last = (addr == last_addr);
    wire match = (dq_sync == dq_out);
    wire sample_now = (state == ST_OE) && adv;
    wire in_prog = (next_ph == PH_FIRST) || (next_ph == PH_RETRY);
    wire pwr_off = (next_state == ST_IDLE) || (next_state == ST_DONE);

    // Two flops on the data pins before any compare
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dq_meta <= '0;
            dq_sync <= '0;
        end
        else if (clk_en)
        begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
        end
    end

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        next_ph = ph;
        next_retry = retry;
        next_addr = addr;
        next_fail = fail_flag;
        case (state)
            ST_IDLE:
            begin
                if (start_prog)
                begin
                    next_state = ST_VCC;
                    next_ph = PH_FIRST;
                    next_addr = '0;
                    next_retry = '0;
                    next_fail = 1'b0;
                end
                else if (start_id)
                begin
                    next_state = ST_SETUP;
                    next_ph = PH_IDENT;
                    next_addr = {{(ADDR_W-1){1'b0}}, id_sel};
                end
            end
            ST_VCC:
                if (adv)
                    next_state = ST_VPP;
            ST_VPP:
                if (adv)
                    next_state = ST_SETUP;
            ST_SETUP:
                if (adv)
                    next_state = (ph == PH_IDENT) ? ST_OE : ST_PULSE;
            ST_PULSE:
                if (adv)
                    next_state = ST_HOLD;
            ST_HOLD:
            begin
                if (adv && ph == PH_FIRST)
                begin
                    // One pulse per address, no verify
                    if (is_last)
                    begin
                        next_state = ST_OE;
                        next_ph = PH_RETRY;
                        next_addr = '0;
                    end
                    else
                    begin
                        next_state = ST_SETUP;
                        next_addr = addr + 1'b1;
                    end
                end
                else if (adv)
                    next_state = ST_OE;
            end
            ST_OE:
                if (adv)
                    next_state = ST_REL;
            ST_REL:
            begin
                if (adv && ph == PH_IDENT)
                    next_state = ST_DONE;
                else if (adv && ph == PH_RETRY)
                begin
                    if (read_ok)
                    begin
                        next_retry = '0;
                        next_state = is_last ? ST_DN_VPP : ST_OE;
                        next_addr = is_last ? addr : addr + 1'b1;
                    end
                    else if (retry == 4'(MAX_RETRY))
                    begin
                        next_fail = 1'b1;
                        next_state = ST_DN_VPP;
                    end
                    else
                    begin
                        next_retry = retry + 1'b1;
                        next_state = ST_SETUP;
                    end
                end
                else if (adv)
                begin
                    // Final read at normal supply
                    if (!read_ok)
                    begin
                        next_fail = 1'b1;
                        next_state = ST_DONE;
                    end
                    else if (is_last)
                        next_state = ST_DONE;
                    else
                    begin
                        next_state = ST_OE;
                        next_addr = addr + 1'b1;
                    end
                end
            end
            ST_DN_VPP:
                if (adv)
                    next_state = ST_DN_VCC;
            ST_DN_VCC:
            begin
                if (adv && fail_flag)
                    next_state = ST_DONE;
                else if (adv)
                begin
                    next_state = ST_OE;
                    next_ph = PH_FINAL;
                    next_addr = '0;
                end
            end
            ST_DONE:
                if (clk_en)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Timer reload on every state change
    assign tmr_load = (next_state != state);
    assign tmr_val =
        (next_state == ST_PULSE) ? TMR_W'(PULSE_CYC - 1) :
        (next_state == ST_OE) ? TMR_W'(CYC_SAMPLE - 1) :
        (next_state == ST_REL) ? TMR_W'(CYC_RELEASE - 1) :
        (next_state == ST_DONE || next_state == ST_IDLE) ? '0 :
        TMR_W'(CYC_SETUP - 1);

    opp_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_done)
    );

    // Pin levels decoded from the next state so every pin is a flop
    wire next_strobe_n = (next_state != ST_PULSE);
    wire next_oe_n = (next_state != ST_OE);
    wire next_dq_oe = in_prog && ((next_state == ST_SETUP) || (next_state == ST_PULSE)
        || (next_state == ST_HOLD));
    wire next_ce_n = pwr_off || (next_state == ST_VCC) || (next_state == ST_VPP)
        || (next_state == ST_DN_VPP) || (next_state == ST_DN_VCC);
    wire next_vcc = in_prog && !pwr_off && (next_state != ST_DN_VCC);
    wire next_vpp = next_vcc && (next_state != ST_VCC) && (next_state != ST_DN_VPP);
    wire next_hv = (next_ph == PH_IDENT) && !pwr_off;

    // State and bookkeeping
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            ph <= PH_FIRST;
            retry <= '0;
            addr <= '0;
            fail_flag <= 1'b0;
            read_ok <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            ph <= next_ph;
            retry <= next_retry;
            addr <= next_addr;
            fail_flag <= next_fail;
            // Verdict held from the sample point; outputs may float once enable rises
            if (sample_now)
                read_ok <= match;
        end
    end

    // Pin flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            program_strobe_n <= 1'b1;
            oe_n <= 1'b1;
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            dq_out <= '0;
            vcc_prog_en <= 1'b0;
            vpp_prog_en <= 1'b0;
            id_high_voltage_line <= 1'b0;
        end
        else if (clk_en)
        begin
            program_strobe_n <= next_strobe_n;
            oe_n <= next_oe_n;
            ce_n <= next_ce_n;
            dq_oe <= next_dq_oe;
            dq_out <= src_data;
            vcc_prog_en <= next_vcc;
            vpp_prog_en <= next_vpp;
            id_high_voltage_line <= next_hv;
        end
    end

    // Status flops; result stands until the next command
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            passed <= 1'b0;
            failed <= 1'b0;
            id_byte <= '0;
        end
        else if (clk_en)
        begin
            busy <= (next_state != ST_IDLE);
            done <= (next_state == ST_DONE);
            if (state == ST_IDLE && (start_prog || start_id))
            begin
                passed <= 1'b0;
                failed <= 1'b0;
            end
            else if (next_state == ST_DONE && ph != PH_IDENT)
            begin
                passed <= !next_fail;
                failed <= next_fail;
            end
            if (state == ST_OE && adv && ph == PH_IDENT)
                id_byte <= dq_sync;
        end
    end

    assign src_addr = addr;

    // Helper counters for checks
    logic [TMR_W-1:0] low_cnt;
    logic [7:0] oe_cnt;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            low_cnt <= '0;
            oe_cnt <= '0;
        end
        else if (clk_en)
        begin
            low_cnt <= program_strobe_n ? '0 : low_cnt + 1'b1;
            oe_cnt <= oe_n ? '0 : oe_cnt + 1'b1;
        end
    end

    sequence s_vcc_alone;
        !vpp_prog_en [*8];
    endsequence

    sequence s_sample_point;
        state == ST_OE && adv;
    endsequence

    a_pulse_width: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(program_strobe_n) |-> low_cnt == TMR_W'(PULSE_CYC))
        else $error("program pulse width wrong");
    a_power_up_order: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(vcc_prog_en) |-> s_vcc_alone)
        else $error("programming supply rose with main supply");
    a_supply_nesting: assert property (@(posedge ref_clk) disable iff (rst)
        vpp_prog_en |-> vcc_prog_en)
        else $error("programming supply without main supply");
    a_start_addr: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(vpp_prog_en) |-> addr == '0)
        else $error("supplies raised away from first address");
    a_first_pass: assert property (@(posedge ref_clk) disable iff (rst)
        (ph == PH_FIRST && state != ST_IDLE) |-> oe_n)
        else $error("verify during first pass");
    a_retry_limit: assert property (@(posedge ref_clk) disable iff (rst)
        retry <= 4'(MAX_RETRY))
        else $error("too many retry pulses");
    a_fail_decide: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_REL && ph == PH_RETRY && adv && !read_ok && retry == 4'(MAX_RETRY))
        |=> fail_flag && state == ST_DN_VPP)
        else $error("exhausted byte not failed");
    a_sample_wait: assert property (@(posedge ref_clk) disable iff (rst)
        s_sample_point |-> oe_cnt >= 8'(CYC_SAMPLE - 1))
        else $error("sampled before output valid");
    a_pulse_pins: assert property (@(posedge ref_clk) disable iff (rst)
        !program_strobe_n |-> (oe_n && !ce_n && dq_oe))
        else $error("bad pins during pulse");
    a_verify_pins: assert property (@(posedge ref_clk) disable iff (rst)
        !oe_n |-> (program_strobe_n && !dq_oe))
        else $error("bad pins during verify");
    a_id_addr_low: assert property (@(posedge ref_clk) disable iff (rst)
        id_high_voltage_line |-> addr[ADDR_W-1:1] == '0)
        else $error("address lines not low in identify");
    a_final_low: assert property (@(posedge ref_clk) disable iff (rst)
        (ph == PH_FINAL) |-> (!vcc_prog_en && !vpp_prog_en))
        else $error("final read not at normal supply");
endmodule // opp_programmer
`default_nettype wire

// ===== opp_device.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural one-time-programmable memory, seen from its pins
module opp_device
    import opp_pkg::*;
#(
    parameter int PULSE_NS = 160,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // Arbitrary value
)
(
    // Device pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic dq_oe,
    input wire logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic program_strobe_n,
    input wire logic id_high_voltage_line,
    input wire logic vcc_prog_en,
    input wire logic vpp_prog_en,
    // Scenario knobs
    input wire logic blank,
    input wire logic slow,
    input wire logic [3:0] hard_addr,
    input wire logic [3:0] hard_pulses,
    input wire logic weak_en,
    input wire logic [3:0] weak_addr
);
    logic [DATA_W-1:0] mem [16];
    int pulses [16];
    int viol;
    int final_reads;
    time t_fall;
    time t_rel;

    initial dq_in = 8'h00;

    // Fresh part: erased cells read all ones
    always @(posedge blank)
    begin
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 8'hFF;
            pulses[i] = 0;
        end
        viol = 0;
        final_reads = 0;
        t_fall = 0;
    end

    // A weak cell only shows its fault at the low supply
    function automatic logic [7:0] cell_read();
        if (id_high_voltage_line)
            return addr[0] ? DEVICE_CODE : MAKER_CODE;
        if (weak_en && !vcc_prog_en && addr[3:0] == weak_addr)
            return ~mem[addr[3:0]];
        return mem[addr[3:0]];
    endfunction

    // Data is late after enable; garbage shows until then, never the old byte
    always @(negedge oe_n)
    begin
        if (id_high_voltage_line && addr[ADDR_W-1:1] != '0)
            viol++;
        dq_in = ~cell_read();
        #(slow ? T_VALID_NS : 20);
        if (!oe_n && !ce_n)
        begin
            dq_in = cell_read();
            if (!vcc_prog_en && !id_high_voltage_line)
                final_reads++;
        end
    end

    // Data goes bad at once; the pins stay driven for the float delay
    always @(posedge oe_n)
    begin
        t_rel = $time;
        dq_in = ~dq_in;
    end

    // Driving data while outputs may still be on is contention
    always @(posedge dq_oe)
        if (!oe_n || $time - t_rel < T_RELEASE_NS)
            viol++;

    // Pulse needs both raised supplies, chip enabled, outputs off
    always @(negedge program_strobe_n)
    begin
        t_fall = $time;
        if (ce_n || !oe_n || !dq_oe || !vcc_prog_en || !vpp_prog_en)
            viol++;
    end

    // Width within five percent; a cell takes only after enough pulses
    always @(posedge program_strobe_n)
    begin
        if (t_fall != 0)
        begin
            if (($time - t_fall) * 20 < PULSE_NS * 19 || ($time - t_fall) * 20 > PULSE_NS * 21)
                viol++;
            pulses[addr[3:0]]++;
            if (pulses[addr[3:0]] >= ((addr[3:0] == hard_addr) ? int'(hard_pulses) : 1))
                mem[addr[3:0]] = mem[addr[3:0]] & dq_out;
        end
    end

    // Main supply leads the programming supply up and trails it down
    always @(posedge vpp_prog_en)
        if (!vcc_prog_en)
            viol++;
    always @(negedge vcc_prog_en)
        if (vpp_prog_en)
            viol++;
endmodule // opp_device
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import opp_pkg::*;
    localparam int PCYC = 20;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rst, clk_en, start_prog, start_id, id_sel;
    logic [ADDR_W-1:0] last_addr, src_addr, addr;
    logic [DATA_W-1:0] src_data, id_byte, dq_out, dq_in;
    logic busy, done, passed, failed, dq_oe, ce_n, oe_n, program_strobe_n;
    logic id_high_voltage_line, vcc_prog_en, vpp_prog_en;
    logic blank, slow, weak_en;
    logic [3:0] hard_addr, hard_pulses, weak_addr;
    int miscompares = 0;
    int checks = 0;

    always #4 ref_clk = ~ref_clk;

    // Source memory answers one cycle after its address
    always @(posedge ref_clk)
        src_data <= 8'h3C ^ src_addr[7:0];

    opp_programmer #(.PULSE_CYC(PCYC)) i_opp_programmer (.ref_clk, .rst, .clk_en,
        .start_prog, .start_id, .id_sel, .last_addr, .src_addr, .src_data, .busy,
        .done, .passed, .failed, .id_byte, .addr, .dq_oe, .dq_out, .dq_in, .ce_n,
        .oe_n, .program_strobe_n, .id_high_voltage_line, .vcc_prog_en, .vpp_prog_en);

    opp_device #(.PULSE_NS(PCYC * CLK_NS), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
        i_opp_device (.addr, .dq_oe, .dq_out, .dq_in, .ce_n, .oe_n, .program_strobe_n,
        .id_high_voltage_line, .vcc_prog_en, .vpp_prog_en, .blank, .slow, .hard_addr,
        .hard_pulses, .weak_en, .weak_addr);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for the completion pulse
    task automatic wait_done(input int limit);
        for (int i = 0; i < limit; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (done === 1'b1)
                return;
        end
        check("done", done, 1'b1);
    endtask

    // Fresh part, one program command, refused identify in mid-run
    task automatic run_prog(input logic [3:0] la, input logic [3:0] ha, input logic [3:0] hp);
        @(posedge ref_clk);
        blank <= 1'b1;
        hard_addr <= ha;
        hard_pulses <= hp;
        last_addr <= {13'h0000, la};
        start_prog <= 1'b1;
        @(posedge ref_clk);
        start_prog <= 1'b0;
        blank <= 1'b0;
        #1 check("busy", busy, 1'b1);
        repeat (40) @(posedge ref_clk);
        start_id <= 1'b1;
        @(posedge ref_clk);
        start_id <= 1'b0;
        wait_done(20000);
        check("id_byte kept", id_byte, DEVICE);
        check("viol", i_opp_device.viol, 0);
    endtask

    // Reset values, and a frozen clock enable ignores a start
    task automatic s_reset();
        @(posedge ref_clk);
        #1 check("idle pins", {busy, done, passed, failed, dq_oe, vcc_prog_en,
            vpp_prog_en, id_high_voltage_line, ce_n, oe_n, program_strobe_n}, 11'h007);
        check("addr", {addr, id_byte}, '0);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        start_id <= 1'b1;
        repeat (3) @(posedge ref_clk);
        start_id <= 1'b0;
        @(posedge ref_clk);
        clk_en <= 1'b1;
        #1 check("frozen busy", busy, 1'b0);
    endtask

    // Both identification bytes, fast and slow device
    task automatic s_ident();
        for (int s = 0; s < 2; s++)
        begin
            @(posedge ref_clk);
            slow <= s[0];
            id_sel <= s[0];
            start_id <= 1'b1;
            @(posedge ref_clk);
            start_id <= 1'b0;
            wait_done(400);
            check("id_byte", id_byte, s ? DEVICE : MAKER);
            check("id viol", i_opp_device.viol, 0);
        end
    endtask

    // Plain run: one pulse each, all read back at low supply
    task automatic s_clean();
        run_prog(4'h3, 4'h0, 4'h1);
        check("passed", {passed, failed}, 2'b10);
        for (int a = 0; a < 4; a++)
        begin
            check("pulses", i_opp_device.pulses[a], 1);
            check("cell", i_opp_device.mem[a], 8'h3C ^ a[7:0]);
        end
        check("final reads", i_opp_device.final_reads, 4);
    endtask

    // Slow device; middle byte takes all ten retries
    task automatic s_retry();
        slow <= 1'b1;
        run_prog(4'h2, 4'h1, 4'hB);
        check("passed", {passed, failed}, 2'b10);
        check("retry pulses", i_opp_device.pulses[1], 11);
        check("next pulses", i_opp_device.pulses[2], 1);
        check("next cell", i_opp_device.mem[2], 8'h3E);
        check("final reads", i_opp_device.final_reads, 3);
    endtask

    // First byte never takes; no final read after the failure
    task automatic s_fail();
        slow <= 1'b0;
        run_prog(4'h2, 4'h0, 4'hC);
        check("failed", {passed, failed}, 2'b01);
        check("fail pulses", i_opp_device.pulses[0], 11);
        check("final reads", i_opp_device.final_reads, 0);
    endtask

    // Byte that verifies high but reads wrong at normal supply
    task automatic s_weak();
        weak_en <= 1'b1;
        weak_addr <= 4'h2;
        run_prog(4'h3, 4'h0, 4'h1);
        check("weak failed", {passed, failed}, 2'b01);
        weak_en <= 1'b0;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        check("watchdog", 1'b1, 1'b0);
        print_verdict();
    end

    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        {start_prog, start_id, id_sel, blank, slow, weak_en} = '0;
        {hard_addr, hard_pulses, weak_addr} = '0;
        last_addr = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset();
        s_ident();
        s_clean();
        s_retry();
        s_fail();
        s_weak();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
